// [core/mss_carrier.sv]
// High carrier selection, polarity and switch synchronization
module mss_carrier (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic other_rst_n,
	mss_car_if.stage cif
);
	logic [15:0] car_vec;
	logic car_raw;
	logic car_pol;
	logic carrier_q;
	logic [7:0] detach_q;
	mss_pkg::mss_state_type state_q;
	mss_pkg::mss_state_type state_d;

	// Carrier source vector; codes 8 and up stay low
	assign car_vec = {8'h00, cif.pwm_out & cif.pwm_mode, cif.ref_clk_sig, cif.cin_two,
		cif.cin_one, 1'b0};
	assign car_raw = car_vec[cif.car_sel];
	assign car_pol = car_raw ^ cif.car_inv;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			carrier_q <= 1'b0;
		else
			carrier_q <= car_pol;
	end

	// Pin detach per carrier channel
	genvar k;
	generate
		for (k = 0; k < mss_pkg::MSS_CAR_CHANS; k++)
		begin : g_det
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					detach_q[k] <= 1'b0;
				else
					detach_q[k] <= cif.car_dis && (cif.car_sel == 4'(k));
			end
		end
	endgenerate

	// Hold high carrier until it falls when sync is on, avoiding truncated pulses
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			mss_pkg::MSS_ST_HIGH:
				if (!cif.mod_sig)
					state_d = (cif.car_sync && car_pol) ? mss_pkg::MSS_ST_WAIT
						: mss_pkg::MSS_ST_LOW;
			mss_pkg::MSS_ST_WAIT:
				if (cif.mod_sig)
					state_d = mss_pkg::MSS_ST_HIGH;
				else if (!car_pol)
					state_d = mss_pkg::MSS_ST_LOW;
			mss_pkg::MSS_ST_LOW:
				if (cif.mod_sig)
					state_d = mss_pkg::MSS_ST_HIGH;
			default:
				state_d = mss_pkg::MSS_ST_LOW;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || !other_rst_n)
			state_q <= mss_pkg::MSS_ST_LOW;
		else
			state_q <= state_d;
	end

	assign cif.carrier = carrier_q;
	assign cif.high_active = (state_q != mss_pkg::MSS_ST_LOW);
	assign cif.car_detach = detach_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !other_rst_n);

	sequence s_fall_req;
		state_q == mss_pkg::MSS_ST_HIGH && !cif.mod_sig && cif.car_sync && car_pol;
	endsequence

	car_invert_a: assert property (1
		|=> carrier_q == ($past(car_raw) ^ $past(cif.car_inv)))
		else $error("carrier polarity wrong");
	sync_hold_a: assert property (s_fall_req ##1 (!cif.mod_sig && car_pol)
		|-> cif.high_active)
		else $error("sync released before carrier fell");
	nosync_switch_a: assert property (state_q == mss_pkg::MSS_ST_HIGH && !cif.mod_sig
		&& !cif.car_sync |=> !cif.high_active)
		else $error("unsynced switch late");
	car_ref_a: assert property (cif.car_sel == mss_pkg::MSS_CAR_REF && !cif.car_inv
		|=> carrier_q == $past(cif.ref_clk_sig))
		else $error("reference carrier not routed");
	car_rsv_a: assert property (cif.car_sel[3] && !cif.car_inv |=> !carrier_q)
		else $error("reserved carrier not low");
endmodule

// [core/mss_top.sv]
// Modulation source select with APB registers and high carrier stage
//
// The placing of the registers and register access over APB were chosen for this implementation.
module mss_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic other_rst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_modulation_input,
	input wire logic [3:0] pwm_out,
	input wire logic [3:0] pwm_mode,
	input wire logic [1:0] comparator_out,
	input wire logic [1:0] serial_data_out,
	input wire logic async_tx_out,
	input wire logic carrier_input_pin_one,
	input wire logic carrier_input_pin_two,
	input wire logic ref_clock_signal,
	output logic modulation_signal,
	output logic [10:0] source_pin_detach,
	output logic high_carrier,
	output logic high_carrier_active,
	output logic [7:0] carrier_pin_detach
);
	mss_car_if cif ();

	logic [7:0] src_q;
	logic [7:0] hcar_q;
	logic [7:0] main_q;
	logic [31:0] prdata_q;
	logic mod_q;
	logic [10:0] src_det_q;
	logic [15:0] src_vec;
	logic mod_d;
	logic [3:0] sel;
	logic src_dis;
	logic soft_bit;
	logic setup;
	logic access;
	logic hit_src;
	logic hit_hcar;
	logic hit_main;
	logic hit_stat;
	logic hit_any;
	logic wr_src;
	logic wr_hcar;
	logic wr_main;
	logic [7:0] stat_byte;
	logic [7:0] rd_byte;

	// APB phase and address decode
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hit_src = (paddr == mss_pkg::MSS_SRC_OFS);
	assign hit_hcar = (paddr == mss_pkg::MSS_HCAR_OFS);
	assign hit_main = (paddr == mss_pkg::MSS_MAIN_OFS);
	assign hit_stat = (paddr == mss_pkg::MSS_STAT_OFS);
	assign hit_any = hit_src || hit_hcar || hit_main || hit_stat;
	assign wr_src = access && pwrite && hit_src;
	assign wr_hcar = access && pwrite && hit_hcar;
	assign wr_main = access && pwrite && hit_main;

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access && !hit_any;
	assign prdata = prdata_q;

	// Field extraction
	assign sel = src_q[3:0];
	assign src_dis = src_q[mss_pkg::MSS_SRC_DIS_BIT];
	assign soft_bit = main_q[mss_pkg::MSS_MAIN_SOFT_BIT];

	// Source control: only the writable bits are kept, so bits 6-4 read zero
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			src_q <= mss_pkg::MSS_SRC_RST;
		else if (wr_src)
			src_q <= pwdata[7:0] & mss_pkg::MSS_SRC_WMASK;
	end

	// High carrier control: disable, invert, sync, bit 4 empty, select
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			hcar_q <= mss_pkg::MSS_HCAR_RST;
		else if (wr_hcar)
			hcar_q <= pwdata[7:0] & mss_pkg::MSS_HCAR_WMASK;
	end

	// Main control: only the soft modulation bit lives here
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			main_q <= mss_pkg::MSS_MAIN_RST;
		else if (wr_main)
			main_q <= pwdata[7:0] & mss_pkg::MSS_MAIN_WMASK;
	end

	// Source vector by selector code; reserved codes read as low
	assign src_vec[0] = soft_bit;
	assign src_vec[1] = external_modulation_input;
	assign src_vec[5:2] = pwm_out & pwm_mode;
	assign src_vec[7:6] = comparator_out;
	assign src_vec[9:8] = serial_data_out;
	assign src_vec[10] = async_tx_out;
	assign src_vec[15:11] = 5'h00;
	assign mod_d = src_vec[sel];

	// Mux output is registered, so a new code acts one cycle after the write
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mod_q <= 1'b0;
		else
			mod_q <= mod_d;
	end

	// Pin detach level for each peripheral channel, held while its code and the disable bit are set
	genvar k;
	generate
		for (k = 0; k < mss_pkg::MSS_SRC_CHANS; k++)
		begin : g_det
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					src_det_q[k] <= 1'b0;
				else
					src_det_q[k] <= src_dis && (sel == 4'(k));
			end
		end
	endgenerate

	// Status byte shows live modulation and carrier state
	always_comb
	begin
		stat_byte = 8'h00;
		stat_byte[mss_pkg::MSS_STAT_MOD_BIT] = mod_q;
		stat_byte[mss_pkg::MSS_STAT_CAR_BIT] = cif.carrier;
		stat_byte[mss_pkg::MSS_STAT_HIGH_BIT] = cif.high_active;
	end

	// Read selection
	assign rd_byte = hit_src ? src_q
		: hit_hcar ? hcar_q
		: hit_main ? main_q
		: hit_stat ? stat_byte
		: 8'h00;

	// Read data captured in the setup cycle, held through the access phase
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			prdata_q <= mss_pkg::MSS_RDATA_RST;
		else if (setup)
			prdata_q <= {24'h00_0000, rd_byte};
	end

	// High carrier stage wiring
	assign cif.car_sel = hcar_q[3:0];
	assign cif.car_inv = hcar_q[mss_pkg::MSS_HC_INV_BIT];
	assign cif.car_sync = hcar_q[mss_pkg::MSS_HC_SYNC_BIT];
	assign cif.car_dis = hcar_q[mss_pkg::MSS_HC_DIS_BIT];
	assign cif.mod_sig = mod_q;
	assign cif.cin_one = carrier_input_pin_one;
	assign cif.cin_two = carrier_input_pin_two;
	assign cif.ref_clk_sig = ref_clock_signal;
	assign cif.pwm_out = pwm_out;
	assign cif.pwm_mode = pwm_mode;

	mss_carrier u_carrier (
		.clk(clk),
		.rst_n(rst_n),
		.other_rst_n(other_rst_n),
		.cif(cif.stage)
	);

	// Outputs
	assign modulation_signal = mod_q;
	assign source_pin_detach = src_det_q;
	assign high_carrier = cif.carrier;
	assign high_carrier_active = cif.high_active;
	assign carrier_pin_detach = cif.car_detach;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_src_write;
		wr_src;
	endsequence

	sequence s_src_read;
		setup && !pwrite && hit_src ##1 access;
	endsequence

	// Register field checks
	src_rsv_a: assert property (s_src_read |-> prdata[6:4] == 3'h0)
		else $error("source reserved bits not zero");
	hcar_rsv_a: assert property (setup && !pwrite && hit_hcar |=> prdata[4] == 1'b0)
		else $error("carrier bit 4 not zero");
	keep_reg_a: assert property (!other_rst_n && !wr_src && !wr_hcar
		|=> $stable(src_q) && $stable(hcar_q))
		else $error("register lost on other reset");
	sel_write_a: assert property (s_src_write |=> sel == $past(pwdata[3:0]))
		else $error("selector not stored");
	src_hold_a: assert property (!wr_src |=> $stable(src_q))
		else $error("source control changed without write");
	hcar_hold_a: assert property (!wr_hcar |=> $stable(hcar_q))
		else $error("carrier control changed without write");
	src_mask_a: assert property (wr_src |=> src_q[6:4] == 3'h0)
		else $error("source reserved bits stored");
	hcar_mask_a: assert property (wr_hcar |=> hcar_q[4] == 1'b0)
		else $error("carrier bit 4 stored");
	hcar_write_a: assert property (wr_hcar
		|=> hcar_q == ($past(pwdata[7:0]) & mss_pkg::MSS_HCAR_WMASK))
		else $error("carrier control not stored");
	src_read_a: assert property (s_src_read
		|-> prdata == {24'h00_0000, $past(src_q)})
		else $error("source control read wrong");
	soft_write_a: assert property (wr_main
		|=> soft_bit == $past(pwdata[mss_pkg::MSS_MAIN_SOFT_BIT]))
		else $error("soft bit not stored");
	main_hold_a: assert property (!wr_main |=> $stable(main_q))
		else $error("soft bit changed without write");

	// Source routing checks
	soft_src_a: assert property (sel == mss_pkg::MSS_SRC_SOFT
		|=> mod_q == $past(soft_bit))
		else $error("soft bit not routed");
	soft_idle_a: assert property (sel != mss_pkg::MSS_SRC_SOFT && sel[3:2] == 2'b11
		|=> mod_q == 1'b0)
		else $error("soft bit leaked");
	pin_src_a: assert property (sel == mss_pkg::MSS_SRC_PIN
		|=> mod_q == $past(external_modulation_input))
		else $error("external pin not routed");
	pwm1_src_a: assert property (sel == mss_pkg::MSS_SRC_PWM1
		|=> mod_q == ($past(pwm_out[0]) && $past(pwm_mode[0])))
		else $error("pwm one not routed");
	pwm2_src_a: assert property (sel == 4'h3
		|=> mod_q == ($past(pwm_out[1]) && $past(pwm_mode[1])))
		else $error("pwm two not routed");
	pwm3_src_a: assert property (sel == 4'h4
		|=> mod_q == ($past(pwm_out[2]) && $past(pwm_mode[2])))
		else $error("pwm three not routed");
	pwm_src_a: assert property (sel == mss_pkg::MSS_SRC_PWM4
		|=> mod_q == ($past(pwm_out[3]) && $past(pwm_mode[3])))
		else $error("pwm four not routed");
	pwm_gate_a: assert property (sel == mss_pkg::MSS_SRC_PWM4 && !pwm_mode[3]
		|=> !mod_q)
		else $error("pwm four passed outside pwm mode");
	cmp1_src_a: assert property (sel == mss_pkg::MSS_SRC_CMP1
		|=> mod_q == $past(comparator_out[0]))
		else $error("comparator one not routed");
	cmp_src_a: assert property (sel == mss_pkg::MSS_SRC_CMP2
		|=> mod_q == $past(comparator_out[1]))
		else $error("comparator two not routed");
	ssp_src_a: assert property (sel == mss_pkg::MSS_SRC_SSP1
		|=> mod_q == $past(serial_data_out[0]))
		else $error("serial one not routed");
	ssp2_src_a: assert property (sel == mss_pkg::MSS_SRC_SSP2
		|=> mod_q == $past(serial_data_out[1]))
		else $error("serial two not routed");
	uart_src_a: assert property (sel == mss_pkg::MSS_SRC_UART
		|=> mod_q == $past(async_tx_out))
		else $error("async transmit not routed");
	rsv_low_a: assert property (sel >= mss_pkg::MSS_SRC_RSV |=> !mod_q)
		else $error("reserved code drives modulation");
	sel_delay_a: assert property (s_src_write ##1 (sel == mss_pkg::MSS_SRC_SOFT)
		|=> mod_q == $past(soft_bit))
		else $error("soft code not applied next cycle");
	new_code_a: assert property (s_src_write ##1 (sel == mss_pkg::MSS_SRC_PIN)
		|=> mod_q == $past(external_modulation_input))
		else $error("new code not applied next cycle");

	// Pin detach checks
	detach_on_a: assert property (src_dis && sel == mss_pkg::MSS_SRC_CMP1
		|=> source_pin_detach == 11'h040)
		else $error("selected pin not detached");
	detach_low_a: assert property (src_dis && sel == mss_pkg::MSS_SRC_SOFT
		|=> source_pin_detach == 11'h001)
		else $error("soft source not flagged");
	detach_pwm_a: assert property (src_dis && sel == mss_pkg::MSS_SRC_PWM1
		|=> source_pin_detach == 11'h004)
		else $error("pwm one pin not detached");
	detach_last_a: assert property (src_dis && sel == mss_pkg::MSS_SRC_UART
		|=> source_pin_detach == 11'h400)
		else $error("transmit pin not detached");
	detach_off_a: assert property (!src_dis |=> source_pin_detach == 11'h000)
		else $error("pin detached while enabled");
	detach_rsv_a: assert property (sel >= mss_pkg::MSS_SRC_RSV
		|=> source_pin_detach == 11'h000)
		else $error("reserved code detaches a pin");

	// Carrier pin detach checks
	car_det_on_a: assert property (cif.car_dis && cif.car_sel == mss_pkg::MSS_CAR_REF
		|=> carrier_pin_detach == 8'h08)
		else $error("reference carrier not detached");
	car_det_off_a: assert property (!cif.car_dis |=> carrier_pin_detach == 8'h00)
		else $error("carrier detached while enabled");
	car_det_rsv_a: assert property (cif.car_sel[3]
		|=> carrier_pin_detach == 8'h00)
		else $error("reserved carrier detaches a pin");
endmodule

// [inc/mss_car_if.sv]
// Links the register side to the high carrier stage
interface mss_car_if;
	logic [3:0] car_sel;
	logic car_inv;
	logic car_sync;
	logic car_dis;
	logic mod_sig;
	logic cin_one;
	logic cin_two;
	logic ref_clk_sig;
	logic [3:0] pwm_out;
	logic [3:0] pwm_mode;
	logic carrier;
	logic high_active;
	logic [7:0] car_detach;
	modport ctrl (output car_sel, car_inv, car_sync, car_dis, mod_sig, cin_one, cin_two,
		ref_clk_sig, pwm_out, pwm_mode, input carrier, high_active, car_detach);
	modport stage (input car_sel, car_inv, car_sync, car_dis, mod_sig, cin_one, cin_two,
		ref_clk_sig, pwm_out, pwm_mode, output carrier, high_active, car_detach);
endinterface

// [inc/mss_pkg.sv]
package mss_pkg;
	// Register byte offsets on the APB
	localparam logic [11:0] MSS_SRC_OFS = 12'h000;
	localparam logic [11:0] MSS_HCAR_OFS = 12'h004;
	localparam logic [11:0] MSS_MAIN_OFS = 12'h008;
	localparam logic [11:0] MSS_STAT_OFS = 12'h00C;
	// Field positions
	localparam int MSS_SRC_DIS_BIT = 7;
	localparam int MSS_HC_DIS_BIT = 7;
	localparam int MSS_HC_INV_BIT = 6;
	localparam int MSS_HC_SYNC_BIT = 5;
	localparam int MSS_MAIN_SOFT_BIT = 0;
	localparam int MSS_STAT_MOD_BIT = 0;
	localparam int MSS_STAT_CAR_BIT = 1;
	localparam int MSS_STAT_HIGH_BIT = 2;
	// Writable bit masks; masked bits read as zero
	localparam logic [7:0] MSS_SRC_WMASK = 8'h8F;
	localparam logic [7:0] MSS_HCAR_WMASK = 8'hEF;
	localparam logic [7:0] MSS_MAIN_WMASK = 8'h01;
	// Power-on values
	localparam logic [7:0] MSS_SRC_RST = 8'h00;
	localparam logic [7:0] MSS_HCAR_RST = 8'h00;
	localparam logic [7:0] MSS_MAIN_RST = 8'h00;
	localparam logic [31:0] MSS_RDATA_RST = 32'h0000_0000;
	// Channel counts
	localparam int MSS_SRC_CHANS = 11;
	localparam int MSS_CAR_CHANS = 8;
	// Modulation source codes
	typedef enum logic [3:0] {
		MSS_SRC_SOFT = 4'h0,
		MSS_SRC_PIN = 4'h1,
		MSS_SRC_PWM1 = 4'h2,
		MSS_SRC_PWM4 = 4'h5,
		MSS_SRC_CMP1 = 4'h6,
		MSS_SRC_CMP2 = 4'h7,
		MSS_SRC_SSP1 = 4'h8,
		MSS_SRC_SSP2 = 4'h9,
		MSS_SRC_UART = 4'hA,
		MSS_SRC_RSV = 4'hB
	} mss_src_type;
	// High carrier source codes
	typedef enum logic [3:0] {
		MSS_CAR_ZERO = 4'h0,
		MSS_CAR_CIN1 = 4'h1,
		MSS_CAR_CIN2 = 4'h2,
		MSS_CAR_REF = 4'h3,
		MSS_CAR_PWM1 = 4'h4,
		MSS_CAR_RSV = 4'h8
	} mss_car_type;
	// Carrier sync states, Gray along high, wait, low
	typedef enum logic [1:0] {
		MSS_ST_HIGH = 2'b00,
		MSS_ST_WAIT = 2'b01,
		MSS_ST_LOW = 2'b11
	} mss_state_type;
endpackage

// [test/mss_src_model.sv]
// Peripheral signal sources facing the modulator inputs
module mss_src_model (
	input wire logic clk,
	output logic external_modulation_input,
	output logic [3:0] pwm_out,
	output logic [3:0] pwm_mode,
	output logic [1:0] comparator_out,
	output logic [1:0] serial_data_out,
	output logic async_tx_out,
	output logic carrier_input_pin_one,
	output logic carrier_input_pin_two,
	output logic ref_clock_signal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] r;
	// Quiet levels before the first edge
	initial
	begin
		{external_modulation_input, pwm_out, pwm_mode, comparator_out} = '0;
		{serial_data_out, async_tx_out, carrier_input_pin_one} = '0;
		{carrier_input_pin_two, ref_clock_signal} = '0;
	end
	// Every source toggles freely so each selector code is told apart
	always @(posedge clk)
	begin
		r = $urandom;
		external_modulation_input <= r[0];
		pwm_out <= r[4:1];
		pwm_mode <= r[8:5]; // Units drift in and out of PWM mode
		comparator_out <= r[10:9];
		serial_data_out <= r[12:11];
		async_tx_out <= r[13];
		carrier_input_pin_one <= r[14];
		carrier_input_pin_two <= r[15];
		ref_clock_signal <= r[16];
	end
endmodule

// [test/test_modulator_source_select.sv]
// Self-checking bench for the modulation source select block
module test_modulator_source_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, other_rst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic ext_in, async_tx, cin_one, cin_two, ref_sig, mod_sig, hc_sig, hc_act;
	logic [3:0] pwm_out, pwm_mode;
	logic [1:0] cmp_out, sdo_out;
	logic [10:0] src_det;
	logic [7:0] car_det;
	logic [7:0] src_b = 8'h00, hcar_b = 8'h00, main_b = 8'h00;
	logic done_q, perr_q;
	logic [33:0] bus_q[$];
	logic [1:0] out_q[$];
	int err_total = 0, n_tests = 0, cyc = 0;

	mss_top dut_u (.clk(clk), .rst_n(rst_n), .other_rst_n(other_rst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .external_modulation_input(ext_in),
		.pwm_out(pwm_out), .pwm_mode(pwm_mode), .comparator_out(cmp_out),
		.serial_data_out(sdo_out), .async_tx_out(async_tx), .carrier_input_pin_one(cin_one),
		.carrier_input_pin_two(cin_two), .ref_clock_signal(ref_sig),
		.modulation_signal(mod_sig), .source_pin_detach(src_det), .high_carrier(hc_sig),
		.high_carrier_active(hc_act), .carrier_pin_detach(car_det));
	mss_src_model src_u (.clk(clk), .external_modulation_input(ext_in), .pwm_out(pwm_out),
		.pwm_mode(pwm_mode), .comparator_out(cmp_out), .serial_data_out(sdo_out),
		.async_tx_out(async_tx), .carrier_input_pin_one(cin_one),
		.carrier_input_pin_two(cin_two), .ref_clock_signal(ref_sig));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Modulation source as the rules define it
	function automatic logic pred_mod(input logic [3:0] c);
		case (c)
			4'h0: return main_b[0];
			4'h1: return ext_in;
			4'h2, 4'h3, 4'h4, 4'h5: return pwm_out[c - 4'h2] & pwm_mode[c - 4'h2];
			4'h6, 4'h7: return cmp_out[c - 4'h6];
			4'h8, 4'h9: return sdo_out[c - 4'h8];
			4'hA: return async_tx;
			default: return 1'b0;
		endcase
	endfunction

	// High carrier source before polarity
	function automatic logic pred_car(input logic [3:0] c);
		case (c)
			4'h1: return cin_one;
			4'h2: return cin_two;
			4'h3: return ref_sig;
			4'h4, 4'h5, 4'h6, 4'h7: return pwm_out[c - 4'h4] & pwm_mode[c - 4'h4];
			default: return 1'b0;
		endcase
	endfunction

	// APB master; the note for the monitor is made at the completing edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		bus_q.push_back({~w, e});
		if (w && a == mss_pkg::MSS_SRC_OFS)
			src_b <= d[7:0] & 8'h8F;
		if (w && a == mss_pkg::MSS_HCAR_OFS)
			hcar_b <= d[7:0] & 8'hEF;
		if (w && a == mss_pkg::MSS_MAIN_OFS)
			main_b <= d[7:0] & 8'h01;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0_0000_0000);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, {1'b0, e});
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic act_chk(input logic e);
		settle(4);
		chk("carrier_active", {32'h0000_0000, hc_act}, {32'h0000_0000, e});
		@(posedge clk);
	endtask

	// Expected outputs one edge after the inputs and settings they follow
	always @(posedge clk)
		out_q.push_back(rst_n ? {pred_mod(src_b[3:0]), pred_car(hcar_b[3:0]) ^ hcar_b[6]} : 2'b00);

	// Mark completed bus transfers and their error flag
	always @(posedge clk)
	begin
		done_q <= psel & penable & pready;
		perr_q <= pslverr;
	end

	// Monitor takes the oldest notes and compares them with what the outputs show
	always @(negedge clk)
	begin
		logic [33:0] n;
		logic [1:0] o;
		if (out_q.size() > 0)
		begin
			o = out_q.pop_front();
			chk("modulation", 33'(mod_sig),
				33'(o[1]));
			chk("high_carrier", 33'(hc_sig), 33'(o[0]));
		end
		if (done_q === 1'b1 && bus_q.size() > 0)
		begin
			n = bus_q.pop_front();
			if (n[33])
				chk("read", {perr_q, prdata}, n[32:0]);
			else
				chk("write_err", {32'h0000_0000, perr_q}, {32'h0000_0000, n[32]});
		end
	end

	// Hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	initial
	begin
		logic [31:0] d, e;
		{psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
		other_rst_n = 1'b1;
		void'($urandom(32'ha314));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(mss_pkg::MSS_SRC_OFS, 32'h0000_0000);
		rd(mss_pkg::MSS_HCAR_OFS, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0000_0000, {1'b1, 32'h0000_0000});
		apb(1'b1, 12'hFFC, $urandom, {1'b1, 32'h0000_0000});
		// Every selector code twice, with random upper and reserved bits
		for (int k = 0; k < 32; k++)
		begin
			d = $urandom;
			e = $urandom;
			wr(mss_pkg::MSS_MAIN_OFS, $urandom);
			wr(mss_pkg::MSS_SRC_OFS, {d[31:4], 4'(k)});
			wr(mss_pkg::MSS_HCAR_OFS, {e[31:4], 4'(k)});
			rd(mss_pkg::MSS_SRC_OFS, {24'h00_0000, d[7], 3'b000, 4'(k)});
			rd(mss_pkg::MSS_HCAR_OFS, {24'h00_0000, e[7:5], 1'b0, 4'(k)});
			settle(8);
			chk("src_detach", 33'(src_det),
				(d[7] && k % 16 < 11) ? 33'(1) << (k % 16) : 33'h0);
			chk("car_detach", 33'(car_det),
				(e[7] && k % 16 < 8) ? 33'(1) << (k % 16) : 33'h0);
			@(posedge clk);
		end
		// Switch to the low carrier with and without synchronization
		wr(mss_pkg::MSS_SRC_OFS, 32'h0000_0000);
		wr(mss_pkg::MSS_HCAR_OFS, 32'h0000_0060);
		wr(mss_pkg::MSS_MAIN_OFS, 32'h0000_0001);
		act_chk(1'b1);
		wr(mss_pkg::MSS_MAIN_OFS, 32'h0000_0000);
		act_chk(1'b1);
		wr(mss_pkg::MSS_HCAR_OFS, 32'h0000_0020);
		act_chk(1'b0);
		wr(mss_pkg::MSS_MAIN_OFS, 32'h0000_0001);
		act_chk(1'b1);
		wr(mss_pkg::MSS_HCAR_OFS, 32'h0000_0040);
		wr(mss_pkg::MSS_MAIN_OFS, 32'h0000_0000);
		act_chk(1'b0);
		// Status shows modulation low, inverted carrier high, carrier idle
		rd(mss_pkg::MSS_STAT_OFS, 32'h0000_0002);
		// Fields survive a reset other than power-on
		wr(mss_pkg::MSS_SRC_OFS, 32'h0000_0085);
		other_rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		other_rst_n <= 1'b1;
		rd(mss_pkg::MSS_SRC_OFS, 32'h0000_0085);
		rd(mss_pkg::MSS_HCAR_OFS, 32'h0000_0040);
		settle(2);
		tally_and_finish();
	end
endmodule
